// ---- rtl/sdc_pkg.sv ----
package sdc_pkg;

  // ----------------------------------------------------------------
  // command codes and frame layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ID_READ = 8'h03;
  localparam logic [7:0] CMD_SETUP = 8'h04;
  localparam logic [7:0] SETUP_MODE_RECALC = 8'h00;

  localparam int FRM_BYTES = 32;
  localparam logic [4:0] FRM_CODE = 5'h00;
  localparam logic [4:0] FRM_WDT = 5'h01;
  localparam logic [4:0] FRM_STAT_LO = 5'h02;
  localparam logic [4:0] FRM_STAT_HI = 5'h03;
  localparam logic [4:0] FRM_MODE = 5'h04;
  localparam logic [4:0] FRM_ID_OFFSET = 5'h05;
  localparam logic [4:0] FRM_ID_SIZE = 5'h06;
  localparam int FRM_ID_DATA = 8;
  localparam int ID_DATA_MAX = 24;
  localparam logic [7:0] ID_SIZE_MAX = 8'h18;
  localparam logic [8:0] ID_MAP_BYTES = 9'h020;

  // ----------------------------------------------------------------
  // supported-command bitmap (selection 30h)
  // ----------------------------------------------------------------
  localparam logic [7:0] ID_SEL_SUPPORTED = 8'h30;
  localparam logic [7:0] SUPP_BYTE0 = 8'h79;
  localparam logic [7:0] SUPP_BYTE1 = 8'he0;
  localparam logic [7:0] SUPP_BYTE4 = 8'h01;
  localparam logic [4:0] SUPP_IDX0 = 5'h00;
  localparam logic [4:0] SUPP_IDX1 = 5'h01;
  localparam logic [4:0] SUPP_IDX4 = 5'h04;

  // ----------------------------------------------------------------
  // status codes and phases
  // ----------------------------------------------------------------
  localparam logic [3:0] ALM_NONE = 4'h0;
  localparam logic [3:0] ALM_INVALID = 4'h9;
  localparam logic [3:0] ALM_PHASE = 4'ha;
  localparam logic [3:0] ALM_UNKNOWN = 4'hb;
  localparam logic [1:0] PHASE_2 = 2'h2;
  localparam logic [1:0] PHASE_3 = 2'h3;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_INT_STATUS = 8'h08;
  localparam logic [7:0] REG_INT_MASK = 8'h0c;
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CTRL_WARN_BIT = 1;
  localparam int CTRL_LINK_LSB = 4;
  localparam int CTRL_PHASE_LSB = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ALARM_BIT = 1;
  localparam int INT_APPLY_BIT = 2;
  localparam int INT_W = 3;
  localparam logic [2:0] INT_RESET = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  localparam int RECALC_TIME_US = 10;
  localparam logic [15:0] RECALC_CYCLES = 16'(RECALC_TIME_US * CLK_MHZ);

  typedef enum logic [1:0] {SDC_IDLE, SDC_BUILD, SDC_SETUP} sdc_state_t;

endpackage

// ---- rtl/sdc_recalc_timer.sv ----
`timescale 1ns/100ps
module sdc_recalc_timer
  import sdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);

  logic [15:0] cnt;

  // a start while busy is ignored so one recalculation never overlaps another
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt <= 16'h0000;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_busy)
      begin
        o_busy <= 1'b1;
        cnt <= RECALC_CYCLES - 16'h0001;
      end
      else if (o_busy && cnt == 16'h0000)
      begin
        o_busy <= 1'b0;
        o_done <= 1'b1;
      end
      else if (o_busy)
        cnt <= cnt - 16'h0001;
    end
  end

endmodule // sdc_recalc_timer

// ---- rtl/sdc_cmd_handler.sv ----
// Overview of operation
// - setup frame: code 04h, response echoes 04h and mode byte, bytes 5-31 zero
// - setup is accepted only in phase 2 or 3
// - unsupported setup mode reports command alarm code 9
// - mode 0 recalculates and applies parameters; no other mode exists
// - ready bit is 1 before, 0 during and 1 after setup processing
// - alarm status holds its current value during setup processing
// - supported-command bitmap reports bits 16-31 as zero
// - invalid id read selection, offset or size reports command alarm 9
`timescale 1ns/100ps
module sdc_cmd_handler
  import sdc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CMD_WR,
  input wire logic [4:0] I_CMD_IDX,
  input wire logic [7:0] I_CMD_BYTE,
  input wire logic I_CMD_GO,
  input wire logic [4:0] I_RSP_IDX,
  output logic [7:0] O_RSP_BYTE,
  output logic O_CMD_READY,
  output logic O_PARAM_APPLY,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // bitmap lookup
  // ----------------------------------------------------------------
  function automatic logic [7:0] supp_byte(input logic [4:0] idx);
    case (idx)
      SUPP_IDX0: supp_byte = SUPP_BYTE0;
      SUPP_IDX1: supp_byte = SUPP_BYTE1;
      SUPP_IDX4: supp_byte = SUPP_BYTE4;
      default: supp_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] cmd [FRM_BYTES];
  logic [7:0] rsp [FRM_BYTES];
  logic [7:0] next_rsp [FRM_BYTES];
  sdc_state_t state;
  logic [31:0] ctrl;
  logic [INT_W-1:0] int_status;
  logic [INT_W-1:0] int_mask;
  logic [3:0] cmd_alarm;
  logic [3:0] next_alarm;
  logic [7:0] response_watchdog_count;
  logic [7:0] last_code;
  logic next_start;
  logic tmr_busy;
  logic tmr_done;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [7:0] cmd_code = cmd[FRM_CODE];
  wire logic [7:0] id_sel = cmd[FRM_MODE];
  wire logic [7:0] id_off = cmd[FRM_ID_OFFSET];
  wire logic [7:0] id_size = cmd[FRM_ID_SIZE];
  wire logic dev_alarm = ctrl[CTRL_ALARM_BIT];
  wire logic dev_warn = ctrl[CTRL_WARN_BIT];
  wire logic [3:0] link_alarm = ctrl[CTRL_LINK_LSB +: 4];
  wire logic [1:0] phase = ctrl[CTRL_PHASE_LSB +: 2];
  wire logic phase_ok = (phase == PHASE_2) || (phase == PHASE_3);
  wire logic [8:0] id_end = {1'b0, id_off} + {1'b0, id_size};
  // a zero size or a window past the bitmap end is refused, not clipped
  wire logic id_ok = (id_sel == ID_SEL_SUPPORTED) &&
                     (id_size != 8'h00) && (id_size <= ID_SIZE_MAX) &&
                     (id_end <= ID_MAP_BYTES);
  wire logic ready = (state == SDC_IDLE);
  wire logic go = I_CMD_GO && ready;
  // alarm flags stay live through setup; the rest is shown as it stands too
  wire logic [7:0] stat_lo = {5'h00, ready, dev_warn, dev_alarm};
  wire logic [7:0] stat_hi = {link_alarm, cmd_alarm};
  // status bytes bypass the frame copy so the master can poll them mid-setup
  wire logic [7:0] rsp_sel = (I_RSP_IDX == FRM_STAT_LO) ? stat_lo :
                             (I_RSP_IDX == FRM_STAT_HI) ? stat_hi : rsp[I_RSP_IDX];

  wire logic apb_access = I_PSEL && I_PENABLE && !O_PREADY;
  wire logic hit_ctrl = I_PADDR == REG_CTRL;
  wire logic hit_stat = I_PADDR == REG_STATUS;
  wire logic hit_int = I_PADDR == REG_INT_STATUS;
  wire logic hit_mask = I_PADDR == REG_INT_MASK;
  wire logic mapped = hit_ctrl || hit_stat || hit_int || hit_mask;
  // a write lands only on the edge at which the master sees pready high,
  // never on the earlier edge that merely starts the answer
  wire logic apb_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  wire logic [INT_W-1:0] int_clr = (apb_wr && hit_int) ? I_PWDATA[INT_W-1:0] : INT_RESET;
  wire logic build_done = (state == SDC_BUILD) && !next_start;
  // each event feeds its own sticky bit; done lands with alarm or with apply, never alarm with apply
  wire logic set_done = build_done || tmr_done;
  wire logic set_alarm = (state == SDC_BUILD) && (next_alarm != ALM_NONE);
  wire logic set_apply = tmr_done;
  wire logic [INT_W-1:0] int_set = {set_apply, set_alarm, set_done};
  wire logic [INT_W-1:0] next_int_status = (int_status & ~int_clr) | int_set;
  wire logic next_irq = |(next_int_status & int_mask);
  // ready drops on the go edge itself, so a second go is never taken
  wire logic next_cmd_ready = (state == SDC_IDLE && !go) ||
                              (state == SDC_BUILD && !next_start) ||
                              (state == SDC_SETUP && tmr_done);
  wire logic [31:0] status_word = {14'h0000, state != SDC_IDLE, tmr_busy,
                                   last_code, cmd_alarm, 3'h0, ready};
  wire logic [31:0] rd_word = hit_ctrl ? ctrl :
                              hit_stat ? status_word :
                              hit_int ? {29'h0, int_status} :
                              hit_mask ? {29'h0, int_mask} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // response assembly
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < FRM_BYTES; i++)
      next_rsp[i] = 8'h00;
    next_rsp[FRM_CODE] = cmd_code;
    next_rsp[FRM_WDT] = response_watchdog_count;
    next_alarm = ALM_NONE;
    next_start = 1'b0;
    case (cmd_code)
      CMD_SETUP:
      begin
        next_rsp[FRM_MODE] = cmd[FRM_MODE];
        if (!phase_ok)
          next_alarm = ALM_PHASE;
        else if (cmd[FRM_MODE] == SETUP_MODE_RECALC)
          next_start = 1'b1;
        else
          next_alarm = ALM_INVALID;
      end
      CMD_ID_READ:
      begin
        next_rsp[FRM_MODE] = id_sel;
        next_rsp[FRM_ID_OFFSET] = id_off;
        next_rsp[FRM_ID_SIZE] = id_size;
        if (!phase_ok)
          next_alarm = ALM_PHASE;
        else if (!id_ok)
          next_alarm = ALM_INVALID;
        // data stays zero on an alarm, so an undefined read shows no stale bytes
        else
          for (int i = 0; i < ID_DATA_MAX; i++)
            if (8'(i) < id_size)
              next_rsp[FRM_ID_DATA + i] = supp_byte(5'(id_end - 9'(id_size) + 9'(i)));
      end
      CMD_NOP: ;
      default: next_alarm = ALM_UNKNOWN;
    endcase
  end

  // ----------------------------------------------------------------
  // command sequencing
  // ----------------------------------------------------------------
  sdc_recalc_timer u_recalc
  (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_start(state == SDC_BUILD && next_start),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // command bytes are taken only while ready, so a frame in flight stays stable
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < FRM_BYTES; i++)
        cmd[i] <= 8'h00;
    end
    else if (I_CMD_WR && ready)
      cmd[I_CMD_IDX] <= I_CMD_BYTE;
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      for (int i = 0; i < FRM_BYTES; i++)
        rsp[i] <= 8'h00;
    end
    else if (state == SDC_BUILD)
      rsp <= next_rsp;
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      state <= SDC_IDLE;
      cmd_alarm <= ALM_NONE;
      response_watchdog_count <= 8'h00;
      last_code <= 8'h00;
    end
    else
    begin
      case (state)
        SDC_IDLE:
          if (go)
            state <= SDC_BUILD;
        SDC_BUILD:
        begin
          cmd_alarm <= next_alarm;
          response_watchdog_count <= response_watchdog_count + 8'h01;
          last_code <= cmd_code;
          // anything but a valid setup finishes in this one cycle
          state <= next_start ? SDC_SETUP : SDC_IDLE;
        end
        SDC_SETUP:
          if (tmr_done)
            state <= SDC_IDLE;
        default: state <= SDC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_RSP_BYTE <= 8'h00;
      O_CMD_READY <= 1'b1;
      O_PARAM_APPLY <= 1'b0;
      O_IRQ <= 1'b0;
    end
    else
    begin
      O_RSP_BYTE <= rsp_sel;
      O_CMD_READY <= next_cmd_ready;
      O_PARAM_APPLY <= tmr_done;
      O_IRQ <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  // one wait state: pready rises on the first access-phase edge and the transfer ends on the second
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      O_PREADY <= apb_access;
      O_PRDATA <= (apb_access && !I_PWRITE) ? rd_word : 32'h0000_0000;
      O_PSLVERR <= apb_access && !mapped;
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      ctrl <= CTRL_RESET;
      int_status <= INT_RESET;
      int_mask <= INT_RESET;
    end
    else
    begin
      int_status <= next_int_status;
      if (apb_wr && hit_ctrl)
        ctrl <= I_PWDATA;
      if (apb_wr && hit_mask)
        int_mask <= I_PWDATA[INT_W-1:0];
    end
  end

endmodule // sdc_cmd_handler

// ---- dv/sdc_cmd_handler_props.sv ----
`timescale 1ns/100ps
module sdc_cmd_handler_props
  import sdc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_CMD_WR,
  input wire logic [4:0] I_CMD_IDX,
  input wire logic [7:0] I_CMD_BYTE,
  input wire logic I_CMD_GO,
  input wire logic [4:0] I_RSP_IDX,
  input wire logic [7:0] O_RSP_BYTE,
  input wire logic O_CMD_READY,
  input wire logic O_PARAM_APPLY,
  input wire logic O_IRQ
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] low_cnt;
  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
      low_cnt <= 16'h0;
    else
      low_cnt <= O_CMD_READY ? 16'h0 : low_cnt + 16'h1;
  end
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  pready_pulse_a: assert property (O_PREADY |=> !O_PREADY) else $error("pready held");
  rdata_idle_a: assert property (!O_PREADY |-> O_PRDATA == 32'h0) else $error("stray rdata");
  slverr_qual_a: assert property (O_PSLVERR |-> O_PREADY) else $error("lone slverr");
  go_busy_a: assert property (I_CMD_GO && O_CMD_READY && $past(O_CMD_READY) |-> ##[1:2] !O_CMD_READY) else $error("ready kept");
  apply_ready_a: assert property (O_PARAM_APPLY |-> O_CMD_READY && !$past(O_CMD_READY)) else $error("apply off ready");
  apply_pulse_a: assert property (O_PARAM_APPLY |=> !O_PARAM_APPLY) else $error("apply held");
  setup_len_a: assert property (O_PARAM_APPLY |-> low_cnt >= RECALC_CYCLES) else $error("short setup");
  alarm_hold_a: assert property (!O_CMD_READY && !$past(O_CMD_READY)
    && I_RSP_IDX == FRM_STAT_LO && $past(I_RSP_IDX) == FRM_STAT_LO
    |=> O_RSP_BYTE[0] == $past(O_RSP_BYTE[0])) else $error("alarm moved");
  cover property (O_PARAM_APPLY);
  cover property (O_PSLVERR);
  cover property (O_IRQ);
endmodule // sdc_cmd_handler_props
bind sdc_cmd_handler sdc_cmd_handler_props i_props (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .I_CMD_WR(I_CMD_WR), .I_CMD_IDX(I_CMD_IDX), .I_CMD_BYTE(I_CMD_BYTE), .I_CMD_GO(I_CMD_GO),
  .I_RSP_IDX(I_RSP_IDX), .O_RSP_BYTE(O_RSP_BYTE), .O_CMD_READY(O_CMD_READY),
  .O_PARAM_APPLY(O_PARAM_APPLY), .O_IRQ(O_IRQ));

// ---- dv/sdc_master_model.sv ----
`timescale 1ns/100ps
module sdc_master_model
  import sdc_pkg::*;
(
  input wire logic i_clk,
  output logic o_cmd_wr,
  output logic [4:0] o_cmd_idx,
  output logic [7:0] o_cmd_byte,
  output logic o_cmd_go,
  output logic [4:0] o_rsp_idx,
  input wire logic [7:0] i_rsp_byte,
  input wire logic i_cmd_ready,
  input wire logic i_param_apply
);
  // ----------------------------------------------------------------
  // frame master
  // ----------------------------------------------------------------
  int n_apply = 0;
  int n_hang = 0;
  initial
  begin
    o_cmd_wr = 1'b0;
    o_cmd_idx = 5'h00;
    o_cmd_byte = 8'h00;
    o_cmd_go = 1'b0;
    o_rsp_idx = 5'h00;
  end
  always @(posedge i_clk)
    if (i_param_apply === 1'b1)
      n_apply++;
  task get(input logic [4:0] idx, output logic [7:0] b);
    @(posedge i_clk);
    o_rsp_idx <= idx;
    repeat (2) @(posedge i_clk);
    b = i_rsp_byte;
  endtask
  task run(input logic [7:0] code, mode, b5, b6, fill, output logic ok,
    output logic [7:0] st2, st3);
    logic [7:0] b0;
    logic [7:0] b4;
    int n;
    for (int i = 0; i < FRM_BYTES; i++)
    begin
      @(posedge i_clk);
      o_cmd_wr <= 1'b1;
      o_cmd_idx <= 5'(i);
      o_cmd_byte <= i == 0 ? code : i == 4 ? mode : i == 5 ? b5 : i == 6 ? b6 : i < 4 ? 8'h00 : fill;
    end
    @(posedge i_clk);
    o_cmd_wr <= 1'b0;
    o_cmd_go <= 1'b1;
    o_rsp_idx <= FRM_STAT_LO;
    @(posedge i_clk);
    o_cmd_go <= 1'b0;
    repeat (2) @(posedge i_clk);
    n = 0;
    while (i_cmd_ready !== 1'b1 && n < 1000)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 1000)
      n_hang++;
    get(FRM_CODE, b0);
    get(FRM_MODE, b4);
    // flags and codes go back to the caller, who follows them up
    get(FRM_STAT_LO, st2);
    get(FRM_STAT_HI, st3);
    ok = (b0 === code) && (b4 === mode) && (st2[2] === 1'b1);
  endtask
endmodule // sdc_master_model

// ---- dv/sdc_cmd_handler_tb_top.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module sdc_cmd_handler_tb_top
  import sdc_pkg::*;
;
  // ----------------------------------------------------------------
  // bench
  // ----------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, cmd_wr, go, rdy, apply, irq, e, ok;
  logic [4:0] cmd_idx, rsp_idx;
  logic [7:0] cmd_byte, rsp_byte, s2, s3, b;
  logic [7:0] exp_map [8] = '{SUPP_BYTE0, SUPP_BYTE1, 8'h00, 8'h00, SUPP_BYTE4, 8'h00, 8'h00, 8'h00};
  logic [7:0] bad [3][3] = '{'{8'h31, 8'h00, 8'h08}, '{8'h30, 8'h00, 8'h00}, '{8'h30, 8'h1e, 8'h08}};
  int n_errors = 0, checks = 0, cyc = 0;
  sdc_cmd_handler i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_CMD_WR(cmd_wr), .I_CMD_IDX(cmd_idx), .I_CMD_BYTE(cmd_byte),
    .I_CMD_GO(go), .I_RSP_IDX(rsp_idx), .O_RSP_BYTE(rsp_byte), .O_CMD_READY(rdy),
    .O_PARAM_APPLY(apply), .O_IRQ(irq));
  sdc_master_model i_mst (.i_clk(clk), .o_cmd_wr(cmd_wr), .o_cmd_idx(cmd_idx),
    .o_cmd_byte(cmd_byte), .o_cmd_go(go), .o_rsp_idx(rsp_idx), .i_rsp_byte(rsp_byte),
    .i_cmd_ready(rdy), .i_param_apply(apply));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 50)
      n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    // let the release edge settle so level outputs are read after it
    @(negedge clk);
  endtask
  task tally_and_finish;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // the whole run needs under a thousand cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    `CHK(rdy, 1'b1)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK(q, CTRL_RESET)
    apb(1'b0, REG_INT_MASK, 32'h0);
    `CHK(q[2:0], INT_RESET)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(e, 1'b1)
    i_mst.run(CMD_SETUP, SETUP_MODE_RECALC, 8'h00, 8'h00, 8'h00, ok, s2, s3);
    `CHK(s3[3:0], ALM_PHASE)
    `CHK(i_mst.n_apply, 0)
    `CHK(irq, 1'b0)
    apb(1'b1, REG_CTRL, 32'h0000_2000);
    apb(1'b1, REG_INT_MASK, 32'h7);
    apb(1'b1, REG_INT_STATUS, 32'h7);
    `CHK(irq, 1'b0)
    // reserved command bytes carry junk on purpose
    i_mst.run(CMD_SETUP, SETUP_MODE_RECALC, 8'hff, 8'hff, 8'hff, ok, s2, s3);
    `CHK(ok, 1'b1)
    `CHK(s3, 8'h00)
    `CHK(i_mst.n_apply, 1)
    for (int i = 5; i < FRM_BYTES; i++)
    begin
      i_mst.get(5'(i), b);
      `CHK(b, 8'h00)
    end
    apb(1'b0, REG_INT_STATUS, 32'h0);
    `CHK(q[2:0], 3'h5)
    `CHK(irq, 1'b1)
    apb(1'b1, REG_INT_STATUS, 32'h5);
    apb(1'b0, REG_INT_STATUS, 32'h0);
    `CHK(q[2:0], 3'h0)
    `CHK(irq, 1'b0)
    apb(1'b1, REG_CTRL, 32'h0000_3001);
    i_mst.run(CMD_SETUP, 8'h05, 8'h00, 8'h00, 8'h00, ok, s2, s3);
    `CHK(s3[3:0], ALM_INVALID)
    `CHK(ok, 1'b1)
    `CHK(i_mst.n_apply, 1)
    `CHK(s2[0], 1'b1)
    i_mst.run(CMD_ID_READ, ID_SEL_SUPPORTED, 8'h00, 8'h08, 8'h00, ok, s2, s3);
    `CHK(s3[3:0], ALM_NONE)
    for (int i = 0; i < 8; i++)
    begin
      i_mst.get(5'(FRM_ID_DATA + i), b);
      `CHK(b, exp_map[i])
    end
    for (int i = 0; i < 3; i++)
    begin
      i_mst.run(CMD_ID_READ, bad[i][0], bad[i][1], bad[i][2], 8'h00, ok, s2, s3);
      `CHK(s3[3:0], ALM_INVALID)
    end
    apb(1'b0, REG_STATUS, 32'h0);
    `CHK(q, 32'h0000_0391)
    `CHK(i_mst.n_hang, 0)
    tally_and_finish();
  end
endmodule // sdc_cmd_handler_tb_top
